// File: hw/pp_gpio_consts.svh
// Register offsets, reset values and field positions of the parallel port block
`ifndef PP_GPIO_CONSTS_SVH
`define PP_GPIO_CONSTS_SVH

`define OFS_PORT_FUNCTION_SELECT  8'h18
`define OFS_PARALLEL_OUTPUT_VALUE 8'h1c
`define OFS_PIN_DIRECTION         8'h20
`define OFS_PIN_TERMINATION       8'h24
`define OFS_RAW_PIN_READBACK      8'h28
`define OFS_PIN_INTERRUPT_ENABLE  8'h2c
`define OFS_RISING_DETECT_ENABLE  8'h30
`define OFS_FALLING_DETECT_ENABLE 8'h34
`define OFS_INPUT_INVERSION       8'h38
`define OFS_EDGE_OR_LEVEL_SELECT  8'h3c
`define OFS_RISING_EVENT_STATUS   8'h40
`define OFS_FALLING_EVENT_STATUS  8'h44
`define OFS_INTERRUPT_SUMMARY     8'h48

`define RST_WORD                  32'h0000_0000
`define RST_PORT_SELECT           8'h00

`define SUM_RISE_ACT_BIT          8
`define SUM_FALL_ACT_BIT          9
`define SUM_LEVEL_ACT_BIT         10
`define SUM_RISE_EN_BIT           16
`define SUM_FALL_EN_BIT           17
`define SUM_LEVEL_EN_BIT          18

`endif

// File: hw/pp_gpio_pkg.sv
// Types shared by the parallel port block
`default_nettype none

package pp_gpio_pkg;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_s;

   typedef struct packed {
      logic [31:0] out;
      logic [31:0] oe;
      logic [31:0] term;
   } pin_drive_s;

   typedef enum logic [1:0] {
      APB_IDLE,
      APB_ACCESS
   } apb_phase_e;

endpackage : pp_gpio_pkg

`default_nettype wire

// File: hw/parallel_port_gpio_mux.sv
// Parallel port that takes over the cable pins of eight serial ports
//
// How it works
// RULE1 - Eight port-select bits, bit 0 is port 1; one picks parallel port
// RULE2 - Reset leaves all ports serial; setting a select bit remaps pins
// RULE3 - Port n owns parallel bits 4(n-1)+3..4(n-1): rts, cts, rx, tx
// RULE4 - Serial mode follows serial logic; parallel mode uses the registers
// RULE5 - Output value register reads back last written word unconditionally
// RULE6 - Data drives a pin only with direction set and port parallel
// RULE7 - Direction resets to zero (inputs); one makes a pin an output
// RULE8 - Software writes output values before setting direction bits
// RULE9 - Serial logic owns direction of pins of non-parallel ports
// RULE10 - Termination bit enables termination; serial logic owns it otherwise
// RULE11 - Raw readback returns all 32 synchronized, unfiltered pin levels
// RULE12 - Interrupt enable lets a pin interrupt in edge or level mode
// RULE13 - Rising enable plus low-to-high input sets rising status bit
// RULE14 - Falling enable plus high-to-low input sets falling status bit
// RULE15 - Change detection works on every pin, outputs included
// RULE16 - Detected edge interrupts only with the pin interrupt enable set
// RULE17 - Inversion bit inverts pin value before processing
// RULE18 - Edge-or-level bit one picks edges, zero picks level processing
// RULE19 - Rising status bits stay latched until written back with ones
// RULE20 - Rising capture needs rising enable and edge select both set
// RULE21 - Each type requests when its active flag and enable are both set
// RULE22 - Level mode requests while adjusted value is high and enabled
// RULE23 - Falling status bits latch and clear by writing ones
`timescale 1ns/1ns
`default_nettype none
`include "pp_gpio_consts.svh"

module parallel_port_gpio_mux #(
   parameter int NUM_PORTS = 8,
   parameter int NUM_BITS  = 32
) (
   // Clock and reset
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   // APB slave
   input  wire pp_gpio_pkg::apb_req_s   apb_req,
   output var  pp_gpio_pkg::apb_rsp_s   apb_rsp,
   // Serial port controls of the pins
   input  wire logic [31:0]             serial_out,
   input  wire logic [31:0]             serial_oe,
   input  wire logic [31:0]             serial_term,
   // Cable pins
   input  wire logic [31:0]             pin_in,
   output var  pp_gpio_pkg::pin_drive_s pin_drive,
   // Parallel port interrupt request
   output logic                         pp_irq
);

   // Only eight ports of four bits each are served
   if (NUM_PORTS != 8 || NUM_BITS != 4 * NUM_PORTS) begin : g_bad_params
      $error("parallel_port_gpio_mux serves eight ports of four bits only");
   end

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0]  port_function_select_r;
   logic [31:0] parallel_output_value_r;
   logic [31:0] pin_direction_r;
   logic [31:0] pin_termination_r;
   logic [31:0] pin_interrupt_enable_r;
   logic [31:0] rising_detect_enable_r;
   logic [31:0] falling_detect_enable_r;
   logic [31:0] input_inversion_r;
   logic [31:0] edge_or_level_select_r;
   logic [31:0] rising_event_status_r;
   logic [31:0] falling_event_status_r;
   logic [2:0]  type_enable_r;
   logic [31:0] sync1_r;
   logic [31:0] sync2_r;
   logic [31:0] adj_prev_r;
   logic        apb_done_r;
   logic [31:0] prdata_r;

   logic        wr_stb;
   logic        rd_stb;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic [31:0] par_mask;
   logic [31:0] adj_val;
   logic [31:0] rise_evt;
   logic [31:0] fall_evt;
   logic [31:0] level_req;
   logic        rise_act;
   logic        fall_act;
   logic        level_act;

   // Expand a per-port select to the four bits that port owns
   function automatic logic [31:0] expand_select(input logic [7:0] sel);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int p = 0; p < 8; p++) begin
         m[4*p +: 4] = {4{sel[p]}};
      end
      return m;
   endfunction : expand_select

   // Write-one-to-clear with the set winning
   function automatic logic [31:0] w1c_next(input logic [31:0] cur,
                                            input logic [31:0] set,
                                            input logic [31:0] clr);
      return (cur & ~clr) | set;
   endfunction : w1c_next

   // ****************************************
   // APB slave
   // ****************************************
   assign addr   = apb_req.paddr;
   assign wdata  = apb_req.pwdata;
   // One wait state: access completes on the second access-phase edge
   assign wr_stb = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_done_r;
   assign rd_stb = apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_done_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_done_r <= 1'b0;
      end else begin
         apb_done_r <= apb_req.psel && apb_req.penable && !apb_done_r;
      end
   end

   always_comb begin
      apb_rsp.prdata  = prdata_r;
      apb_rsp.pready  = apb_done_r;
      apb_rsp.pslverr = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= `RST_WORD;
      end else if (apb_req.psel && apb_req.penable && !apb_req.pwrite && !apb_done_r) begin
         case (addr)
            `OFS_PORT_FUNCTION_SELECT:  prdata_r <= {24'h00_0000, port_function_select_r}; // [RULE1]
            `OFS_PARALLEL_OUTPUT_VALUE: prdata_r <= parallel_output_value_r; // [RULE5]
            `OFS_PIN_DIRECTION:         prdata_r <= pin_direction_r;
            `OFS_PIN_TERMINATION:       prdata_r <= pin_termination_r;
            `OFS_RAW_PIN_READBACK:      prdata_r <= sync2_r; // [RULE11]
            `OFS_PIN_INTERRUPT_ENABLE:  prdata_r <= pin_interrupt_enable_r;
            `OFS_RISING_DETECT_ENABLE:  prdata_r <= rising_detect_enable_r;
            `OFS_FALLING_DETECT_ENABLE: prdata_r <= falling_detect_enable_r;
            `OFS_INPUT_INVERSION:       prdata_r <= input_inversion_r;
            `OFS_EDGE_OR_LEVEL_SELECT:  prdata_r <= edge_or_level_select_r;
            `OFS_RISING_EVENT_STATUS:   prdata_r <= rising_event_status_r; // [RULE19]
            `OFS_FALLING_EVENT_STATUS:  prdata_r <= falling_event_status_r; // [RULE23]
            `OFS_INTERRUPT_SUMMARY: begin
               prdata_r <= `RST_WORD;
               prdata_r[`SUM_RISE_ACT_BIT]  <= rise_act; // [RULE21]
               prdata_r[`SUM_FALL_ACT_BIT]  <= fall_act;
               prdata_r[`SUM_LEVEL_ACT_BIT] <= level_act;
               prdata_r[`SUM_RISE_EN_BIT]   <= type_enable_r[0];
               prdata_r[`SUM_FALL_EN_BIT]   <= type_enable_r[1];
               prdata_r[`SUM_LEVEL_EN_BIT]  <= type_enable_r[2];
            end
            default:                    prdata_r <= `RST_WORD;
         endcase
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_function_select_r <= `RST_PORT_SELECT; // [RULE2]
      end else if (wr_stb && addr == `OFS_PORT_FUNCTION_SELECT) begin
         port_function_select_r <= wdata[7:0]; // [RULE1]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         parallel_output_value_r <= `RST_WORD;
         pin_direction_r         <= `RST_WORD; // [RULE7]
         pin_termination_r       <= `RST_WORD;
         pin_interrupt_enable_r  <= `RST_WORD;
         rising_detect_enable_r  <= `RST_WORD;
         falling_detect_enable_r <= `RST_WORD;
         input_inversion_r       <= `RST_WORD;
         edge_or_level_select_r  <= `RST_WORD;
         type_enable_r           <= 3'h0;
      end else if (wr_stb) begin
         case (addr)
            `OFS_PARALLEL_OUTPUT_VALUE: parallel_output_value_r <= wdata;
            `OFS_PIN_DIRECTION:         pin_direction_r         <= wdata; // [RULE7]
            `OFS_PIN_TERMINATION:       pin_termination_r       <= wdata;
            `OFS_PIN_INTERRUPT_ENABLE:  pin_interrupt_enable_r  <= wdata;
            `OFS_RISING_DETECT_ENABLE:  rising_detect_enable_r  <= wdata;
            `OFS_FALLING_DETECT_ENABLE: falling_detect_enable_r <= wdata;
            `OFS_INPUT_INVERSION:       input_inversion_r       <= wdata;
            `OFS_EDGE_OR_LEVEL_SELECT:  edge_or_level_select_r  <= wdata;
            `OFS_INTERRUPT_SUMMARY:     type_enable_r <= wdata[`SUM_LEVEL_EN_BIT:`SUM_RISE_EN_BIT];
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // Pin muxing
   // ****************************************
   assign par_mask = expand_select(port_function_select_r); // [RULE3]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_drive <= '0;
      end else begin
         // Parallel ports take every control from registers, others from serial logic
         pin_drive.out  <= (par_mask & parallel_output_value_r) | (~par_mask & serial_out); // [RULE4]
         pin_drive.oe   <= (par_mask & pin_direction_r) | (~par_mask & serial_oe); // [RULE6] [RULE9]
         pin_drive.term <= (par_mask & pin_termination_r) | (~par_mask & serial_term); // [RULE10]
      end
   end

   // ****************************************
   // Input sampling and change detection
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= `RST_WORD;
         sync2_r <= `RST_WORD;
      end else begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r; // [RULE11]
      end
   end

   // Pins read the cable regardless of direction
   assign adj_val = sync2_r ^ input_inversion_r; // [RULE15] [RULE17]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adj_prev_r <= `RST_WORD;
      end else begin
         adj_prev_r <= adj_val;
      end
   end

   assign rise_evt = adj_val & ~adj_prev_r & rising_detect_enable_r & edge_or_level_select_r; // [RULE13] [RULE20]
   assign fall_evt = ~adj_val & adj_prev_r & falling_detect_enable_r & edge_or_level_select_r; // [RULE14] [RULE18]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rising_event_status_r  <= `RST_WORD;
         falling_event_status_r <= `RST_WORD;
      end else begin
         rising_event_status_r <= w1c_next(rising_event_status_r, rise_evt,
            (wr_stb && addr == `OFS_RISING_EVENT_STATUS) ? wdata : `RST_WORD); // [RULE19]
         falling_event_status_r <= w1c_next(falling_event_status_r, fall_evt,
            (wr_stb && addr == `OFS_FALLING_EVENT_STATUS) ? wdata : `RST_WORD); // [RULE23]
      end
   end

   // ****************************************
   // Interrupt request
   // ****************************************
   assign level_req = adj_val & ~edge_or_level_select_r & pin_interrupt_enable_r; // [RULE22]
   assign rise_act  = |(rising_event_status_r & pin_interrupt_enable_r); // [RULE12] [RULE16]
   assign fall_act  = |(falling_event_status_r & pin_interrupt_enable_r); // [RULE16]
   assign level_act = |level_req;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pp_irq <= 1'b0;
      end else begin
         pp_irq <= (rise_act & type_enable_r[0]) | (fall_act & type_enable_r[1])
                 | (level_act & type_enable_r[2]); // [RULE21]
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_reset_serial;
      @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> port_function_select_r == 8'h00;
   endproperty
   a_reset_serial: assert property (p_reset_serial) else $error("select not serial"); // [RULE2]

   property p_serial_oe;
      @(posedge pclk) disable iff (!presetn)
      presetn && !port_function_select_r[0] |=> pin_drive.oe[3:0] == $past(serial_oe[3:0]);
   endproperty
   a_serial_oe: assert property (p_serial_oe) else $error("serial oe not followed"); // [RULE9]

   property p_par_oe;
      @(posedge pclk) disable iff (!presetn)
      port_function_select_r[1] |=> pin_drive.oe[7:4] == $past(pin_direction_r[7:4]);
   endproperty
   a_par_oe: assert property (p_par_oe) else $error("parallel oe wrong"); // [RULE6]

   property p_par_out;
      @(posedge pclk) disable iff (!presetn)
      port_function_select_r[1] |=> pin_drive.out[7:4] == $past(parallel_output_value_r[7:4]);
   endproperty
   a_par_out: assert property (p_par_out) else $error("parallel out wrong"); // [RULE4]

   property p_term;
      @(posedge pclk) disable iff (!presetn)
      port_function_select_r[1] |=> pin_drive.term[7:4] == $past(pin_termination_r[7:4]);
   endproperty
   a_term: assert property (p_term) else $error("termination wrong"); // [RULE10]

   sequence s_rise_edge;
      !sync2_r[8] && !input_inversion_r[8]
         ##1 sync2_r[8] && !input_inversion_r[8] && rising_detect_enable_r[8]
         && edge_or_level_select_r[8];
   endsequence
   property p_rise_capture;
      @(posedge pclk) disable iff (!presetn)
      s_rise_edge |=> rising_event_status_r[8];
   endproperty
   a_rise_capture: assert property (p_rise_capture) else $error("rise lost"); // [RULE13]

   property p_rise_gate;
      @(posedge pclk) disable iff (!presetn)
      !edge_or_level_select_r[9] && !rising_event_status_r[9] |=> !rising_event_status_r[9];
   endproperty
   a_rise_gate: assert property (p_rise_gate) else $error("rise without edge mode"); // [RULE20]

   property p_fall_hold;
      @(posedge pclk) disable iff (!presetn)
      falling_event_status_r[10] && !(wr_stb && addr == `OFS_FALLING_EVENT_STATUS)
         |=> falling_event_status_r[10];
   endproperty
   a_fall_hold: assert property (p_fall_hold) else $error("fall status dropped"); // [RULE23]

   property p_rise_clear;
      @(posedge pclk) disable iff (!presetn)
      wr_stb && addr == `OFS_RISING_EVENT_STATUS && wdata[8] && !rise_evt[8]
         |=> !rising_event_status_r[8];
   endproperty
   a_rise_clear: assert property (p_rise_clear) else $error("rise not cleared"); // [RULE19]

   property p_level_irq;
      @(posedge pclk) disable iff (!presetn)
      type_enable_r[2] && level_req[11] |=> pp_irq;
   endproperty
   a_level_irq: assert property (p_level_irq) else $error("level irq missing"); // [RULE22]

   property p_dataout_rb;
      @(posedge pclk) disable iff (!presetn)
      wr_stb && addr == `OFS_PARALLEL_OUTPUT_VALUE |=> parallel_output_value_r == $past(wdata);
   endproperty
   a_dataout_rb: assert property (p_dataout_rb) else $error("output value lost"); // [RULE5]

   property p_output_value_read;
      @(posedge pclk) disable iff (!presetn)
      rd_stb && addr == `OFS_PARALLEL_OUTPUT_VALUE
         |-> apb_rsp.prdata == parallel_output_value_r;
   endproperty
   a_output_value_read: assert property (p_output_value_read) else $error("output value read"); // [RULE5]

   sequence s_fall_edge;
      sync2_r[10] && !input_inversion_r[10]
         ##1 !sync2_r[10] && !input_inversion_r[10] && falling_detect_enable_r[10]
         && edge_or_level_select_r[10];
   endsequence
   property p_fall_capture;
      @(posedge pclk) disable iff (!presetn)
      s_fall_edge |=> falling_event_status_r[10];
   endproperty
   a_fall_capture: assert property (p_fall_capture) else $error("fall lost"); // [RULE14]

   property p_raw_readback;
      @(posedge pclk) disable iff (!presetn)
      presetn ##1 presetn |=> sync2_r == $past(pin_in, 2);
   endproperty
   a_raw_readback: assert property (p_raw_readback) else $error("readback not synced"); // [RULE11]

   property p_irq_needs_enable;
      @(posedge pclk) disable iff (!presetn)
      pin_interrupt_enable_r == 32'h0000_0000 |=> !pp_irq;
   endproperty
   a_irq_needs_enable: assert property (p_irq_needs_enable) else $error("irq not enabled"); // [RULE16]

   property p_dir_reset;
      @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> pin_direction_r == 32'h0000_0000;
   endproperty
   a_dir_reset: assert property (p_dir_reset) else $error("direction not input"); // [RULE7]

endmodule : parallel_port_gpio_mux
`default_nettype wire

// File: dv/cable_model.sv
// Far end of the cable: differential lines seen by the block's receivers
`timescale 1ns/1ns
`default_nettype none

module cable_model (
   // Block side
   input  wire pp_gpio_pkg::pin_drive_s pin_drive,
   // Level the remote end puts on each line
   input  wire logic [31:0]             cable_val,
   // Level seen at the receivers
   output logic [31:0]                  pin_in
);

   // A driven line reads back its own level, an undriven one the remote level
   assign pin_in = (pin_drive.oe & pin_drive.out) | (~pin_drive.oe & cable_val);

endmodule : cable_model

`default_nettype wire

// File: dv/parallel_port_gpio_mux_tb.sv
// Self-checking testbench of the parallel port block
`timescale 1ns/1ns
`default_nettype none
`include "pp_gpio_consts.svh"

module parallel_port_gpio_mux_tb;

   // ****************************************************************
   // Constants and signals
   // ****************************************************************
   localparam logic [31:0] SO    = 32'ha5a5_5a5a;
   localparam logic [31:0] SOE   = 32'h0f0f_f00f;
   localparam logic [31:0] ST    = 32'h3c3c_c3c3;
   localparam logic [31:0] OUTV  = 32'h1234_5678;
   localparam logic [31:0] CAB0  = 32'h5a00_0c33;
   localparam logic [31:0] CAB1  = CAB0 ^ 32'h0000_0700;
   localparam logic [31:0] M     = 32'h0000_00f0;
   localparam logic [31:0] IEN_T [6] = '{32'h10, 32'h0, 32'h10, 32'h400, 32'h800, 32'h800};
   localparam logic [31:0] SUM_T [6] = '{32'h0001_0000, 32'h0001_0000, 32'h0,
                                         32'h0002_0000, 32'h0004_0000, 32'h0004_0000};
   localparam logic [31:0] EXP_T [6] = '{32'h0001_0100, 32'h0001_0000, 32'h0000_0100,
                                         32'h0002_0200, 32'h0004_0000, 32'h0004_0400};
   localparam logic [31:0] CAB_T [6] = '{CAB1, CAB1, CAB1, CAB1, CAB1, CAB1 & ~32'h800};
   localparam logic [5:0]  IRQ_T     = 6'h29;

   logic                    pclk;
   logic                    presetn;
   pp_gpio_pkg::apb_req_s   apb_req;
   pp_gpio_pkg::apb_rsp_s   apb_rsp;
   pp_gpio_pkg::pin_drive_s pin_drive;
   logic [31:0]             serial_out;
   logic [31:0]             serial_oe;
   logic [31:0]             serial_term;
   logic [31:0]             pin_in;
   logic [31:0]             cable_val;
   logic [31:0]             rd;
   logic [31:0]             dirv;
   logic [31:0]             oe_x;
   logic                    pp_irq;
   int                      n_fail;
   int                      checks;

   parallel_port_gpio_mux DUT (
      .pclk        (pclk),
      .presetn     (presetn),
      .apb_req     (apb_req),
      .apb_rsp     (apb_rsp),
      .serial_out  (serial_out),
      .serial_oe   (serial_oe),
      .serial_term (serial_term),
      .pin_in      (pin_in),
      .pin_drive   (pin_drive),
      .pp_irq      (pp_irq)
   );

   cable_model u_cable (
      .pin_drive (pin_drive),
      .cable_val (cable_val),
      .pin_in    (pin_in)
   );

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic print_verdict();
      if (n_fail == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   // One APB transfer; read data lands in rd
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         chk(32'h0, 32'h1);
      end
      rd = apb_rsp.prdata;
      chk({31'h0, apb_rsp.pslverr}, 32'h0);
      apb_req.psel    <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask : xfer

   task automatic pins(input logic [31:0] oe, input logic [31:0] out, input logic [31:0] term);
      repeat (2) @(posedge pclk);
      chk(pin_drive.oe, oe);
      chk(pin_drive.out & pin_drive.oe, out & oe);
      chk(pin_drive.term, term);
   endtask : pins

   // ****************************************************************
   // Clock, watchdog and tests
   // ****************************************************************
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      print_verdict();
   end

   initial begin
      presetn     = 1'b0;
      apb_req     = '0;
      serial_out  = SO;
      serial_oe   = SOE;
      serial_term = ST;
      cable_val   = CAB0;
      n_fail      = 0;
      checks      = 0;
      repeat (2) @(posedge pclk);
      chk(pin_drive.oe, 32'h0);
      presetn <= 1'b1;
      for (int a = 'h18; a <= 'h48; a += 4) begin
         if (a != 'h28) begin
            xfer(1'b0, 8'(a), 32'h0);
            chk(rd, 32'h0);
         end
      end
      pins(SOE, SO, ST);
      for (int a = 'h1c; a <= 'h3c; a += 4) begin
         if (a != 'h28) begin
            xfer(1'b1, 8'(a), 32'h9e37_0000 | 32'(a));
            xfer(1'b0, 8'(a), 32'h0);
            chk(rd, 32'h9e37_0000 | 32'(a));
         end
      end
      pins(SOE, SO, ST);
      xfer(1'b1, `OFS_PORT_FUNCTION_SELECT, 32'hffff_ff02);
      xfer(1'b0, `OFS_PORT_FUNCTION_SELECT, 32'h0);
      chk(rd, 32'h0000_0002);
      xfer(1'b1, `OFS_PARALLEL_OUTPUT_VALUE, OUTV);
      xfer(1'b1, `OFS_PIN_TERMINATION, 32'h0000_0050);
      for (int i = 0; i < 2; i++) begin
         dirv = (i == 0) ? 32'hffff_ffff : 32'h0000_0030;
         xfer(1'b1, `OFS_PIN_DIRECTION, dirv);
         pins((SOE & ~M) | (dirv & M), (SO & ~M) | (OUTV & M), (ST & ~M) | 32'h50);
      end
      xfer(1'b0, `OFS_PARALLEL_OUTPUT_VALUE, 32'h0);
      chk(rd, OUTV);
      oe_x = (SOE & ~M) | 32'h30;
      xfer(1'b1, `OFS_RAW_PIN_READBACK, 32'hffff_ffff);
      xfer(1'b0, `OFS_RAW_PIN_READBACK, 32'h0);
      chk(rd, (oe_x & ((SO & ~M) | (OUTV & M))) | (~oe_x & CAB0));
      xfer(1'b1, `OFS_RISING_DETECT_ENABLE, 32'h0000_0310);
      xfer(1'b1, `OFS_FALLING_DETECT_ENABLE, 32'h0000_0400);
      xfer(1'b1, `OFS_EDGE_OR_LEVEL_SELECT, 32'h0000_0510);
      xfer(1'b1, `OFS_INPUT_INVERSION, 32'h0000_0800);
      xfer(1'b1, `OFS_PIN_INTERRUPT_ENABLE, 32'h0);
      xfer(1'b1, `OFS_PARALLEL_OUTPUT_VALUE, OUTV & ~32'h10);
      repeat (4) @(posedge pclk);
      xfer(1'b1, `OFS_RISING_EVENT_STATUS, 32'hffff_ffff);
      xfer(1'b1, `OFS_FALLING_EVENT_STATUS, 32'hffff_ffff);
      cable_val <= CAB1;
      xfer(1'b1, `OFS_PARALLEL_OUTPUT_VALUE, OUTV);
      repeat (4) @(posedge pclk);
      xfer(1'b0, `OFS_RISING_EVENT_STATUS, 32'h0);
      chk(rd, 32'h0000_0110);
      xfer(1'b0, `OFS_FALLING_EVENT_STATUS, 32'h0);
      chk(rd, 32'h0000_0400);
      for (int i = 0; i < 6; i++) begin
         cable_val <= CAB_T[i];
         xfer(1'b1, `OFS_PIN_INTERRUPT_ENABLE, IEN_T[i]);
         xfer(1'b1, `OFS_INTERRUPT_SUMMARY, SUM_T[i]);
         repeat (4) @(posedge pclk);
         xfer(1'b0, `OFS_INTERRUPT_SUMMARY, 32'h0);
         chk(rd, EXP_T[i]);
         chk({31'h0, pp_irq}, {31'h0, IRQ_T[i]});
      end
      xfer(1'b0, `OFS_RISING_EVENT_STATUS, 32'h0);
      chk(rd, 32'h0000_0110);
      xfer(1'b1, `OFS_RISING_EVENT_STATUS, 32'h0000_0100);
      xfer(1'b0, `OFS_RISING_EVENT_STATUS, 32'h0);
      chk(rd, 32'h0000_0010);
      xfer(1'b1, `OFS_FALLING_EVENT_STATUS, 32'h0000_0400);
      xfer(1'b0, `OFS_FALLING_EVENT_STATUS, 32'h0);
      chk(rd, 32'h0);
      print_verdict();
   end

endmodule : parallel_port_gpio_mux_tb

`default_nettype wire
